// [src/kvmq_pkg.sv]
// constants for the console peripheral qualifier and channel selector
// assumes a 100 MHz system clock and one enumeration engine per switch
`default_nettype none
package kvmq_pkg;
    localparam int CLK_MHZ = 100;
    // longest wait for an enumeration answer, in microseconds
    localparam int QRY_TIMEOUT_US = 100;
    localparam int QRY_TIMEOUT_CYC = QRY_TIMEOUT_US * CLK_MHZ;
    // usb interface class code for human interface devices
    localparam logic [7:0] HID_CLASS = 8'h03;
    // console port positions inside the keyboard and mouse group
    localparam int KBD_PORT = 0;
    localparam int MOUSE_PORT = 1;
    localparam int NUM_PORTS = 2;
    localparam int NUM_HOSTS = 4;
    localparam int RPT_W = 8;
    typedef enum logic [0:0] {Q_IDLE, Q_WAIT} kvmq_state_t;
endpackage
`default_nettype wire

// [src/kvmq_switch.sv]
// keyboard and mouse channel selector with console peripheral qualifier
// assumes an emulating usb host engine that enumerates on request and
// answers on the same clock; buttons and attach lines are raw pins
`default_nettype none
// How it works
// - keyboard and mouse ports share one group, routed to one host at most.
// - host requests to change channel are ignored; only user buttons select.
// - a single-button press routes to exactly one host; none before any press.
// - no data path exists between any two host interfaces.
// - console port data goes only to the selected host, never other ports.
// - only hid devices and qualified hubs or composites are accepted per port; others queried then rejected.
// - unauthorized devices behind hubs rejected; option rejects all hubs.
// - each port is queried on attach and at power-up before enabling.
// - hub or composite admitted only with filtering, hid endpoint, rest off.
module kvmq_switch
    import kvmq_pkg::*;
#(
    parameter int N_HOST = NUM_HOSTS,
    parameter int N_PORT = NUM_PORTS,
    parameter int QRY_TMO = QRY_TIMEOUT_CYC,
    parameter bit REJECT_ALL_HUBS = 1'b0,
    localparam int PW = (N_PORT > 1) ? $clog2(N_PORT) : 1,
    localparam int CW = $clog2(QRY_TMO + 1)
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [N_HOST-1:0] usr_btn_in,
    input wire logic [N_HOST-1:0] host_sel_req,
    input wire logic [N_PORT-1:0] att_in,
    output logic qry_req_r,
    output logic [PW-1:0] qry_port_r,
    input wire logic ans_valid,
    input wire logic [7:0] ans_class,
    input wire logic ans_hub,
    input wire logic ans_comp,
    input wire logic ans_filt,
    input wire logic ans_hid_ep,
    input wire logic ans_rest_off,
    input wire logic rpt_valid,
    input wire logic [PW-1:0] rpt_port,
    input wire logic [RPT_W-1:0] rpt_data,
    output logic [N_PORT-1:0] port_ok_r,
    output logic [N_HOST-1:0] km_host_r,
    output logic [N_HOST-1:0] host_valid_r,
    output logic [RPT_W-1:0] host_data_r,
    output logic host_req_ignored_r
);
    logic [N_HOST-1:0] btn_m_r, btn_s_r, btn_d_r;
    logic [N_HOST-1:0] hreq_m_r, hreq_s_r, hreq_d_r;
    logic [N_PORT-1:0] att_m_r, att_s_r, att_d_r;
    logic [N_PORT-1:0] att_rise, pend_r, pend_nxt;
    logic usr_take, ans_auth, fwd_ok, issue;
    logic [PW-1:0] issue_port;
    logic [CW-1:0] cnt_r;
    kvmq_state_t st_r;

    // lowest pending port wins the enumeration engine
    function automatic logic [PW-1:0] pick(input logic [N_PORT-1:0] v);
        logic [PW-1:0] p;
        p = '0;
        for (int i = N_PORT - 1; i >= 0; i--)
        begin
            if (v[i])
                p = PW'(i);
        end
        return p;
    endfunction

    // admission check on one enumeration answer
    function automatic logic qualify(
        input logic [7:0] cls,
        input logic multi,
        input logic filt,
        input logic hid_ep,
        input logic rest_off
    );
        if (multi)
            return !REJECT_ALL_HUBS && filt && hid_ep && rest_off;
        return cls == HID_CLASS;
    endfunction

    // two-stage synchronisers on every pin
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            btn_m_r <= '0;
            btn_s_r <= '0;
            btn_d_r <= '0;
            hreq_m_r <= '0;
            hreq_s_r <= '0;
            hreq_d_r <= '0;
            att_m_r <= '0;
            att_s_r <= '0;
            att_d_r <= '0;
        end
        else
        begin
            btn_m_r <= usr_btn_in;
            btn_s_r <= btn_m_r;
            btn_d_r <= btn_s_r;
            hreq_m_r <= host_sel_req;
            hreq_s_r <= hreq_m_r;
            hreq_d_r <= hreq_s_r;
            att_m_r <= att_in;
            att_s_r <= att_m_r;
            att_d_r <= att_s_r;
        end
    end

    // sync flops clear at reset, so a device present at power-up
    // shows up as a fresh attach and gets queried too
    assign att_rise = att_s_r & ~att_d_r;
    // two buttons held at once is ambiguous and selects nothing
    assign usr_take = $onehot(btn_s_r) && |(btn_s_r & ~btn_d_r);
    assign ans_auth = qualify(ans_class, ans_hub | ans_comp, ans_filt,
        ans_hid_ep, ans_rest_off);
    assign issue = (st_r == Q_IDLE) && |pend_r;
    assign issue_port = pick(pend_r);
    assign fwd_ok = rpt_valid && port_ok_r[rpt_port] && |km_host_r;

    // channel choice: user buttons only, one host for the whole group
    always_ff @(posedge clk)
    begin
        if (srst)
            km_host_r <= '0;
        else if (usr_take)
            km_host_r <= btn_s_r;
    end

    // host channel requests are only flagged, never obeyed
    always_ff @(posedge clk)
    begin
        if (srst)
            host_req_ignored_r <= 1'b0;
        else
            host_req_ignored_r <= |(hreq_s_r & ~hreq_d_r);
    end

    // pending queries: attach sets, issue clears, set wins
    always_comb
    begin
        pend_nxt = pend_r;
        if (issue)
            pend_nxt[issue_port] = 1'b0;
        pend_nxt = (pend_nxt | att_rise) & att_s_r;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            pend_r <= '0;
        else
            pend_r <= pend_nxt;
    end

    // port latched at issue and held through the wait, so it stands
    // beside qry_req_r and the answer lands on the port it belongs to
    always_ff @(posedge clk)
    begin
        if (srst)
            qry_port_r <= '0;
        else if (issue)
            qry_port_r <= issue_port;
    end

    // query sequencer; a silent engine counts as a refusal
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_r <= Q_IDLE;
            qry_req_r <= 1'b0;
            cnt_r <= '0;
        end
        else
        begin
            qry_req_r <= issue;
            unique case (st_r)
                Q_IDLE:
                begin
                    cnt_r <= '0;
                    if (issue)
                        st_r <= Q_WAIT;
                end
                Q_WAIT:
                begin
                    cnt_r <= cnt_r + CW'(1);
                    if (ans_valid || cnt_r == CW'(QRY_TMO - 1))
                        st_r <= Q_IDLE;
                end
            endcase
        end
    end

    // admission state per console port
    always_ff @(posedge clk)
    begin
        if (srst)
            port_ok_r <= '0;
        else
        begin
            for (int p = 0; p < N_PORT; p++)
            begin
                if (!att_s_r[p] || att_rise[p] || pend_r[p])
                    port_ok_r[p] <= 1'b0;
                else if (st_r == Q_WAIT && qry_port_r == PW'(p))
                begin
                    if (ans_valid)
                        port_ok_r[p] <= ans_auth;
                    else if (cnt_r == CW'(QRY_TMO - 1))
                        port_ok_r[p] <= 1'b0;
                end
            end
        end
    end

    // reports flow one way, console to the selected host only;
    // there is no path into any console port or between hosts
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            host_valid_r <= '0;
            host_data_r <= '0;
        end
        else
        begin
            host_valid_r <= fwd_ok ? km_host_r : '0;
            if (fwd_ok)
                host_data_r <= rpt_data;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    AST_TIED: assert property (|host_valid_r |->
        (host_valid_r & ~km_host_r) == '0)
        else $error("report sent to a host outside the group channel");
    AST_NO_HOST_CTRL: assert property (!usr_take |=> $stable(km_host_r))
        else $error("channel changed without a user press");
    AST_ONE_HOST: assert property ($onehot0(km_host_r))
        else $error("group routed to more than one host");
    AST_TAKE: assert property (usr_take |=> km_host_r == $past(btn_s_r))
        else $error("user press did not select its host");
    AST_NO_CROSS: assert property ($onehot0(host_valid_r))
        else $error("report copied to more than one host");
    AST_SRC_OK: assert property (|host_valid_r |-> $past(fwd_ok))
        else $error("report forwarded from an unqualified port");
    AST_REFUSE: assert property (st_r == Q_WAIT && ans_valid && !ans_auth
        |=> !port_ok_r[$past(qry_port_r)])
        else $error("unauthorized device admitted");
    AST_HUB: assert property (st_r == Q_WAIT && ans_valid &&
        (ans_hub || ans_comp) && (REJECT_ALL_HUBS || !ans_filt)
        |=> !port_ok_r[$past(qry_port_r)])
        else $error("hub admitted against policy");
    AST_ATTACH: assert property (att_rise[0] |=> pend_r[0])
        else $error("attach did not schedule a query");
    AST_HOLD: assert property (pend_r[0] |-> !port_ok_r[0])
        else $error("port enabled before qualification");
    AST_MULTI: assert property (st_r == Q_WAIT && ans_valid &&
        (ans_hub || ans_comp) && !(ans_hid_ep && ans_rest_off)
        |=> !port_ok_r[$past(qry_port_r)])
        else $error("composite admitted without hid and disabled rest");
endmodule
`default_nettype wire

// [verif/kvmq_engine_model.sv]
// stand-in for the usb enumeration engine facing the console ports
// assumes the switch clock and one outstanding query at a time
`default_nettype none
module kvmq_engine_model
#(
    parameter int DLY = 10
)
(
    input wire logic clk,
    input wire logic qry_req_r,
    input wire logic [7:0] d_class,
    input wire logic [4:0] d_flags,
    output logic ans_valid,
    output logic [7:0] ans_class,
    output logic [4:0] ans_flags
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    // idle lines carry inverted data so a stale descriptor never matches
    always @(posedge clk)
    begin
        ans_valid <= 1'b0;
        ans_class <= ~d_class;
        ans_flags <= ~d_flags;
        if (qry_req_r)
            cnt <= DLY;
        else if (cnt > 1)
            cnt <= cnt - 1;
        else if (cnt == 1)
        begin
            cnt <= 0;
            ans_valid <= 1'b1;
            ans_class <= d_class;
            ans_flags <= d_flags;
        end
    end
endmodule
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the channel selector and port qualifier
// assumes the engine model answers each query well inside QRY_TMO
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import kvmq_pkg::*;
    logic clk = 0, srst = 1, qreq, qport, av, rv = 0, rport = 0, ign;
    logic [3:0] btn = 0, hreq = 0, km, hv, hv_or = 0;
    logic [1:0] att = 2'b01, ok;
    logic [7:0] acls, rdata = 0, hd, dcls = 8'h03;
    logic [4:0] af, dfl = 0;
    int err_total = 0, comparisons = 0, cyc = 0, n_ign = 0, n_hv = 0;
    int n_q = 0;
    logic q_last = 0;
    kvmq_switch #(.QRY_TMO(20)) u_dut (.clk(clk), .srst(srst),
        .usr_btn_in(btn), .host_sel_req(hreq), .att_in(att),
        .qry_req_r(qreq), .qry_port_r(qport), .ans_valid(av),
        .ans_class(acls), .ans_hub(af[4]), .ans_comp(af[3]),
        .ans_filt(af[2]), .ans_hid_ep(af[1]), .ans_rest_off(af[0]),
        .rpt_valid(rv), .rpt_port(rport), .rpt_data(rdata),
        .port_ok_r(ok), .km_host_r(km), .host_valid_r(hv),
        .host_data_r(hd), .host_req_ignored_r(ign));
    kvmq_engine_model u_eng (.clk(clk), .qry_req_r(qreq), .d_class(dcls),
        .d_flags(dfl), .ans_valid(av), .ans_class(acls), .ans_flags(af));
    always #5 clk = ~clk;
    // pulse counters, so one-cycle outputs are never missed;
    // held off in reset, while the outputs may still be unknown
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (!srst)
        begin
            if (ign === 1'b1)
                n_ign <= n_ign + 1;
            if (hv !== 4'h0)
                n_hv <= n_hv + 1;
            hv_or <= hv_or | hv;
            if (qreq === 1'b1)
            begin
                n_q <= n_q + 1;
                q_last <= qport;
            end
        end
        if (cyc == 2000)
        begin
            err_total++;
            wrap_up;
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic press(input logic [3:0] b);
        btn <= b;
        tick(6);
        btn <= 4'h0;
        tick(3);
    endtask
    // port held at power-up is queried; nothing routed before a press
    task automatic t_reset;
        tick(2);
        chk(8'(ok), 8'h0);
        chk(8'(km), 8'h0);
        tick(20);
        chk(8'(ok), 8'h1);
        chk(8'(n_q), 8'h1);
        chk(8'(q_last), 8'h0);
    endtask
    task automatic t_select;
        hreq <= 4'b0010;
        tick(6);
        hreq <= 4'h0;
        chk(8'(n_ign), 8'h1);
        chk(8'(km), 8'h0);
        press(4'b0011);
        chk(8'(km), 8'h0);
        press(4'b0100);
        chk(8'(km), 8'h04);
        hreq <= 4'b0001;
        tick(6);
        hreq <= 4'h0;
        chk(8'(km), 8'h04);
    endtask
    // re-attach with a descriptor; early report must be dropped
    task automatic t_att(input int p, input logic [7:0] c,
        input logic [4:0] f, input logic exp);
        int n0, q0;
        att[p] <= 1'b0;
        tick(4);
        n0 = n_hv;
        q0 = n_q;
        dcls <= c;
        dfl <= f;
        att[p] <= 1'b1;
        tick(4);
        rv <= 1'b1;
        rport <= p[0];
        rdata <= 8'h5A;
        tick(1);
        rv <= 1'b0;
        tick(20);
        chk(8'(n_hv - n0), 8'h0);
        chk(8'(ok[p]), 8'(exp));
        chk(8'(n_q - q0), 8'h1);
        chk(8'(q_last), 8'(p));
    endtask
    task automatic send(input logic p, input logic [7:0] d);
        rv <= 1'b1;
        rport <= p;
        rdata <= d;
        tick(1);
    endtask
    // back-to-back bytes from both ports follow the selected host
    task automatic t_reports;
        int n0;
        n0 = n_hv;
        send(1'b0, 8'hA5);
        send(1'b1, 8'h3C);
        rv <= 1'b0;
        tick(3);
        chk(8'(n_hv - n0), 8'h2);
        chk(8'(hv_or), 8'h04);
        chk(hd, 8'h3C);
        press(4'b0001);
        send(1'b1, 8'hC3);
        rv <= 1'b0;
        tick(3);
        chk(8'(hv_or), 8'h05);
        chk(hd, 8'hC3);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        tick(3);
        srst <= 1'b0;
        t_reset;
        t_select;
        t_att(1, 8'h08, 5'b00000, 1'b0);
        t_att(1, 8'h09, 5'b10111, 1'b1);
        t_att(1, 8'h09, 5'b10011, 1'b0);
        t_att(1, 8'h03, 5'b01101, 1'b0);
        t_att(1, 8'h03, 5'b01110, 1'b0);
        t_att(0, 8'h03, 5'b00000, 1'b1);
        t_att(1, 8'h03, 5'b00000, 1'b1);
        t_reports;
        wrap_up;
    end
endmodule
`default_nettype wire
